// ---- verilog/cwf_codec_frame.sv ----
// codec end of the four-word control/sample frame
// assumes host words and converter samples are on core_clk; pio_in is a pin
`timescale 1ns/100ps

// Functional notes
// - output word bit 15 enables headphones, bit 14 line out, bit 6 preset_a, bit 7 is kept zero.
// - output word bits 13..8 and 5..0 give left and right attenuation in 1.5 dB steps, zero none.
// - input word bits 15..14 are the parallel bits and bit 12 picks line (0) or microphone (1).
// - input word bits 11..8 and 3..0 give left and right input gain in 1.5 dB steps, zero none.
// - input word bits 7..4 attenuate the monitor path in 1.5 dB steps, 15 mutes it.
// - input word bit 13 reads one once an over-range is seen in a cycle where the last input word written before that cycle had bit 13 set.
// - the overrange flag stays one until the host writes zero to that bit.
// - converted input passes the monitor attenuator and is added to the output converter data.
// - blocks are four words: inbound left, right, output, input word; outbound input, left, right, output word.
module cwf_codec_frame #(
   parameter int SAMPLE_W = 16
) (
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic                 clk_en,
   input  wire logic                 rx_valid,
   input  wire logic [15:0]          rx_word,
   output logic                      rx_ready,
   output logic                      tx_valid,
   output logic [15:0]               tx_word,
   input  wire logic                 tx_ready,
   input  wire logic                 adc_valid,
   input  wire cwf_pkg::cwf_stereo_t adc_sample,
   input  wire logic                 adc_over,
   input  wire logic [1:0]           pio_in,
   output cwf_pkg::cwf_stereo_t      dac_sample,
   output logic                      dac_valid,
   output cwf_pkg::cwf_out_set_t     out_cfg,
   output cwf_pkg::cwf_in_set_t      in_cfg
);

   if (SAMPLE_W != cwf_pkg::WORD_W) begin : g_chk
      $error("sample width must equal the frame word width");
   end

   cwf_pkg::cwf_state_t  q;
   cwf_pkg::cwf_state_t  d;
   logic                 acc_rx;
   logic                 wr_in_set;
   logic                 pop;
   logic                 push;
   logic [15:0]          tx_w;
   cwf_pkg::cwf_in_set_t wi;
   cwf_pkg::cwf_in_set_t ri;

   // ********************************
   // monitor mixing
   // ********************************
   // roughly 1.5 dB per step in Q8
   function automatic logic [8:0] cwf_gain(input logic [3:0] att);
      logic [8:0] g;
      g = 9'h000;
      case (att)
         4'h0: g = 9'h100;
         4'h1: g = 9'h0D7;
         4'h2: g = 9'h0B5;
         4'h3: g = 9'h098;
         4'h4: g = 9'h080;
         4'h5: g = 9'h06C;
         4'h6: g = 9'h05B;
         4'h7: g = 9'h04C;
         4'h8: g = 9'h040;
         4'h9: g = 9'h036;
         4'hA: g = 9'h02D;
         4'hB: g = 9'h026;
         4'hC: g = 9'h020;
         4'hD: g = 9'h01B;
         4'hE: g = 9'h017;
         default: g = 9'h000;
      endcase
      return g;
   endfunction : cwf_gain

   // adds the attenuated input sample to the host sample, saturating
   function automatic logic signed [15:0] cwf_mix(input logic signed [15:0] h, input logic signed [15:0] a,
                                                 input logic [3:0] att);
      logic signed [25:0] p;
      logic signed [17:0] s;
      p = a * $signed({1'b0, cwf_gain(att)});
      s = 18'(h) + 18'(p >>> cwf_pkg::MON_FRAC);
      if (s > 18'sh07FFF) begin
         return 16'sh7FFF;
      end else if (s < -18'sh08000) begin
         return 16'sh8000;
      end
      return s[15:0];
   endfunction : cwf_mix

   // ********************************
   // next state
   // ********************************
   always_comb begin
      d = q;
      wi = cwf_pkg::cwf_in_set_t'(rx_word);
      acc_rx = rx_valid & q.rx_ready;
      wr_in_set = acc_rx && (q.rx_idx == cwf_pkg::OB_INSET);
      pop = q.tx_valid & tx_ready;
      d.rx_ready = 1'b1;
      d.dac_valid = 1'b0;
      d.pio_s1 = pio_in;
      d.pio_s2 = q.pio_s1;
      if (acc_rx) begin
         d.rx_idx = q.rx_idx + 2'h1;
         case (q.rx_idx)
            cwf_pkg::OB_INSET: begin
               d.in_cfg.parallel_io_bits = wi.parallel_io_bits;
               d.in_cfg.input_source_sel = wi.input_source_sel;
               d.in_cfg.left_in_gain = wi.left_in_gain;
               d.in_cfg.right_in_gain = wi.right_in_gain;
               d.in_cfg.monitor_atten = wi.monitor_atten;
               d.ovr_en = wi.overrange_flag;
            end
            cwf_pkg::OB_LEFT: begin
               d.host.left = rx_word;
            end
            cwf_pkg::OB_RIGHT: begin
               d.host.right = rx_word;
            end
            default: begin
               d.out_cfg = cwf_pkg::cwf_out_set_t'(rx_word);
               d.out_cfg.rsvd_zero = 1'b0;
               d.dac.left = cwf_mix(q.host.left, q.adc.left, q.in_cfg.monitor_atten);
               d.dac.right = cwf_mix(q.host.right, q.adc.right, q.in_cfg.monitor_atten);
               d.dac_valid = 1'b1;
            end
         endcase
      end
      // an event in the clearing cycle still sets the flag
      d.in_cfg.overrange_flag = (q.in_cfg.overrange_flag & ~(wr_in_set & ~rx_word[cwf_pkg::IN_OVR_BIT]))
                              | (adc_over & q.ovr_en);
      // inbound word for the current slot
      ri = q.in_cfg;
      ri.parallel_io_bits = q.pio_s2;
      case (q.tx_idx)
         cwf_pkg::IB_LEFT: tx_w = q.snap.left;
         cwf_pkg::IB_RIGHT: tx_w = q.snap.right;
         cwf_pkg::IB_OUTSET: tx_w = q.out_cfg;
         default: tx_w = ri;
      endcase
      push = (q.tx_st == cwf_pkg::CWF_SEND) && ((q.buf_cnt != cwf_pkg::BUF_DEPTH) || pop);
      case (q.tx_st)
         cwf_pkg::CWF_IDLE: begin
            if (q.pend) begin
               d.tx_st = cwf_pkg::CWF_SEND;
               d.tx_idx = cwf_pkg::IB_LEFT;
               d.snap = q.adc;
               d.pend = 1'b0;
            end
         end
         default: begin
            if (push) begin
               d.tx_idx = q.tx_idx + 2'h1;
               if (q.tx_idx == cwf_pkg::IB_INSET) begin
                  d.tx_st = cwf_pkg::CWF_IDLE;
               end
            end
         end
      endcase
      if (adc_valid) begin
         d.adc = adc_sample;
         d.pend = 1'b1;
      end
      // two-entry buffer, head drives the port
      case ({push, pop})
         2'b10: begin
            if (q.buf_cnt == 2'h0) begin
               d.buf_head = tx_w;
            end else begin
               d.buf_tail = tx_w;
            end
            d.buf_cnt = q.buf_cnt + 2'h1;
         end
         2'b01: begin
            d.buf_head = q.buf_tail;
            d.buf_cnt = q.buf_cnt - 2'h1;
         end
         2'b11: begin
            if (q.buf_cnt == 2'h1) begin
               d.buf_head = tx_w;
            end else begin
               d.buf_head = q.buf_tail;
               d.buf_tail = tx_w;
            end
         end
         default: begin
            d.buf_cnt = q.buf_cnt;
         end
      endcase
      d.tx_valid = (d.buf_cnt != 2'h0);
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         q <= cwf_pkg::ST_RST;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign rx_ready   = q.rx_ready;
   assign tx_valid   = q.tx_valid;
   assign tx_word    = q.buf_head;
   assign dac_sample = q.dac;
   assign dac_valid  = q.dac_valid;
   assign out_cfg    = q.out_cfg;
   assign in_cfg     = q.in_cfg;

   // ********************************
   // checks
   // ********************************
   a_rsvd_bit_zero: assert property (@(posedge core_clk) disable iff (reset)
      !out_cfg.rsvd_zero) else $error("reserved output bit not zero");

   a_out_word_load: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && acc_rx && q.rx_idx == cwf_pkg::OB_OUTSET |=>
      out_cfg.left_out_atten == $past(rx_word[13:8]) && out_cfg.headphone_out_en == $past(rx_word[15]))
      else $error("output settings not loaded");

   a_src_sel_load: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && wr_in_set |=> in_cfg.input_source_sel == $past(rx_word[cwf_pkg::IN_SRC_BIT]))
      else $error("input source not loaded");

   a_ovr_set: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && adc_over && q.ovr_en |=> in_cfg.overrange_flag) else $error("overrange not flagged");

   a_ovr_sticky: assert property (@(posedge core_clk) disable iff (reset)
      in_cfg.overrange_flag && !(clk_en && wr_in_set && !rx_word[cwf_pkg::IN_OVR_BIT]) |=>
      in_cfg.overrange_flag) else $error("overrange flag dropped");

   a_ovr_clear: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && wr_in_set && !rx_word[cwf_pkg::IN_OVR_BIT] && !adc_over |=> !in_cfg.overrange_flag)
      else $error("overrange flag not cleared");

   a_mute_mix: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && acc_rx && q.rx_idx == cwf_pkg::OB_OUTSET && q.in_cfg.monitor_atten == cwf_pkg::MON_MUTE |=>
      dac_valid && dac_sample == $past(q.host)) else $error("muted monitor leaked");

   a_dac_pulse: assert property (@(posedge core_clk) disable iff (reset)
      dac_valid && clk_en && !(acc_rx && q.rx_idx == cwf_pkg::OB_OUTSET) |=> !dac_valid)
      else $error("output strobe longer than one cycle");

   a_tx_first_left: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && push && q.buf_cnt == 2'h0 && q.tx_idx == cwf_pkg::IB_LEFT |=>
      tx_valid && tx_word == $past(q.snap.left))
      else $error("block does not open with left sample");

   a_tx_hold: assert property (@(posedge core_clk) disable iff (reset)
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_word)) else $error("stalled word lost");

   a_rx_stay_ready: assert property (@(posedge core_clk) disable iff (reset)
      rx_ready |=> rx_ready)
      else $error("host side stopped accepting words");

   a_in_gain_load: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && wr_in_set |=> in_cfg.left_in_gain == $past(rx_word[11:8]) && in_cfg.right_in_gain == $past(rx_word[3:0]))
      else $error("input gains not loaded");

   a_mon_load: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && wr_in_set |=> in_cfg.monitor_atten == $past(rx_word[7:4]))
      else $error("monitor attenuation not loaded");

   a_in_hold: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !wr_in_set |=> $stable(in_cfg.left_in_gain) && $stable(in_cfg.right_in_gain)
      && $stable(in_cfg.monitor_atten) && $stable(in_cfg.input_source_sel)) else $error("input settings drifted");

   a_out_en_load: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && acc_rx && q.rx_idx == cwf_pkg::OB_OUTSET |=> out_cfg.line_out_en == $past(rx_word[14])
      && out_cfg.preset_a_out_en == $past(rx_word[6]) && out_cfg.right_out_atten == $past(rx_word[5:0]))
      else $error("output enables not loaded");

   a_out_hold: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !(acc_rx && q.rx_idx == cwf_pkg::OB_OUTSET) |=> $stable(out_cfg))
      else $error("output settings changed outside slot");

   a_dac_cause: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !(acc_rx && q.rx_idx == cwf_pkg::OB_OUTSET) |=> !dac_valid)
      else $error("output strobe without a closing word");

   a_ovr_off: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !q.ovr_en && !in_cfg.overrange_flag |=> !in_cfg.overrange_flag)
      else $error("overrange flagged with detection off");

   a_pio_report: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && push && q.tx_idx == cwf_pkg::IB_INSET && (q.buf_cnt == 2'h0 || (q.buf_cnt == 2'h1 && pop)) |=>
      tx_word[15:14] == $past(q.pio_s2)) else $error("parallel pins not reported");

   a_clk_freeze: assert property (@(posedge core_clk) disable iff (reset)
      !clk_en |=> $stable(in_cfg) && $stable(out_cfg) && $stable(tx_word) && $stable(dac_sample))
      else $error("state moved while clock enable low");

   a_buf_bound: assert property (@(posedge core_clk) disable iff (reset)
      q.buf_cnt <= cwf_pkg::BUF_DEPTH && tx_valid == (q.buf_cnt != 2'h0))
      else $error("buffer count out of range");

endmodule : cwf_codec_frame

// ---- verilog/cwf_pkg.sv ----
// codec frame block: constants, field layouts and state type
// assumes 16-bit frame words and one core clock
package cwf_pkg;

   // ********************************
   // frame layout
   // ********************************
   localparam int         WORD_W     = 16;
   localparam logic [1:0] OB_INSET   = 2'h0;
   localparam logic [1:0] OB_LEFT    = 2'h1;
   localparam logic [1:0] OB_RIGHT   = 2'h2;
   localparam logic [1:0] OB_OUTSET  = 2'h3;
   localparam logic [1:0] IB_LEFT    = 2'h0;
   localparam logic [1:0] IB_RIGHT   = 2'h1;
   localparam logic [1:0] IB_OUTSET  = 2'h2;
   localparam logic [1:0] IB_INSET   = 2'h3;
   localparam int         IN_OVR_BIT = 13;
   localparam int         IN_SRC_BIT = 12;
   localparam logic [3:0] MON_MUTE   = 4'hF;
   localparam int         MON_FRAC   = 8;
   localparam logic [1:0] BUF_DEPTH  = 2'h2;

   // ********************************
   // settings words
   // ********************************
   typedef struct packed {
      logic       headphone_out_en;
      logic       line_out_en;
      logic [5:0] left_out_atten;
      logic       rsvd_zero;
      logic       preset_a_out_en;
      logic [5:0] right_out_atten;
   } cwf_out_set_t;

   typedef struct packed {
      logic [1:0] parallel_io_bits;
      logic       overrange_flag;
      logic       input_source_sel;
      logic [3:0] left_in_gain;
      logic [3:0] monitor_atten;
      logic [3:0] right_in_gain;
   } cwf_in_set_t;

   typedef struct packed {
      logic signed [15:0] left;
      logic signed [15:0] right;
   } cwf_stereo_t;

   typedef enum logic {CWF_IDLE = 1'b0, CWF_SEND = 1'b1} cwf_tx_st_t;

   localparam logic [15:0] OUT_SET_RST = 16'h0000;
   localparam logic [15:0] IN_SET_RST  = 16'h00F0;

   typedef struct packed {
      logic         rx_ready;
      logic [1:0]   rx_idx;
      cwf_out_set_t out_cfg;
      cwf_in_set_t  in_cfg;
      logic         ovr_en;
      cwf_stereo_t  host;
      cwf_stereo_t  adc;
      cwf_stereo_t  snap;
      cwf_stereo_t  dac;
      logic         dac_valid;
      logic         pend;
      cwf_tx_st_t   tx_st;
      logic [1:0]   tx_idx;
      logic [15:0]  buf_head;
      logic [15:0]  buf_tail;
      logic [1:0]   buf_cnt;
      logic         tx_valid;
      logic [1:0]   pio_s1;
      logic [1:0]   pio_s2;
   } cwf_state_t;

   localparam cwf_state_t ST_RST = '{out_cfg: OUT_SET_RST, in_cfg: IN_SET_RST, tx_st: CWF_IDLE, default: '0};

endpackage : cwf_pkg

// ---- tb/cwf_host_model.sv ----
// host-side model: sink of inbound words, stores them in a circular sample space
// assumes the block's valid/ready handshake on core_clk
`timescale 1ns/100ps
module cwf_host_model (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic        stall,
   input  wire logic        tx_valid,
   input  wire logic [15:0] tx_word,
   output logic             tx_ready,
   output logic             got_valid,
   output logic [15:0]      got_word
);
   logic [15:0] x_space [0:7];
   logic [2:0]  shared_sample_pointer;

   // ****************************************
   // sink with optional stall
   // ****************************************
   assign tx_ready = ~stall;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         got_valid             <= 1'b0;
         got_word              <= 16'h0000;
         shared_sample_pointer <= 3'h0;
      end else begin
         got_valid <= clk_en & tx_valid & tx_ready;
         if (clk_en & tx_valid & tx_ready) begin
            got_word                         <= tx_word;
            x_space[shared_sample_pointer]   <= tx_word;
            shared_sample_pointer            <= shared_sample_pointer + 3'h1;
         end
      end
   end
endmodule : cwf_host_model

// ---- tb/tb.sv ----
// testbench: host tasks send outbound blocks, converter pulses make inbound blocks
// assumes cwf_host_model as sink of inbound words and a 200 MHz core clock
`timescale 1ns/100ps
module tb;
   logic                  core_clk, reset, clk_en, rx_valid, rx_ready, tx_valid, tx_ready;
   logic                  adc_valid, adc_over, dac_valid, stall, got_valid;
   logic [15:0]           rx_word, tx_word, got_word, adc_l, adc_r;
   logic [1:0]            pio_in;
   cwf_pkg::cwf_stereo_t  adc_sample, dac_sample;
   cwf_pkg::cwf_out_set_t out_cfg;
   cwf_pkg::cwf_in_set_t  in_cfg;
   logic [15:0]           q[$];
   logic [15:0]           exp_w [0:7];
   int                    errors, check_count;

   cwf_codec_frame #(.SAMPLE_W(16)) u_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
      .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_word(tx_word),
      .tx_ready(tx_ready), .adc_valid(adc_valid), .adc_sample(adc_sample), .adc_over(adc_over),
      .pio_in(pio_in), .dac_sample(dac_sample), .dac_valid(dac_valid), .out_cfg(out_cfg), .in_cfg(in_cfg));
   cwf_host_model u_host (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .stall(stall),
      .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready), .got_valid(got_valid), .got_word(got_word));

   // ****************************************
   // clock, word capture, tasks
   // ****************************************
   always #2.5 core_clk = ~core_clk;

   always @(negedge core_clk) begin
      if (got_valid === 1'b1) q.push_back(got_word);
   end

   task automatic summarize;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   task automatic sendw(input logic [15:0] w);
      int i;
      rx_valid = 1'b1;
      rx_word = w;
      i = 0;
      while (rx_ready !== 1'b1 && i < 20) begin
         step(1);
         i++;
      end
      chk(rx_ready, 1'b1);
      step(1);
   endtask : sendw

   // stalls until n inbound words have arrived
   task automatic wait_words(input int n);
      int i;
      i = 0;
      while (q.size() < n && i < 40) begin
         step(1);
         i++;
      end
   endtask : wait_words

   // expected converter word: host sample plus unity or muted monitor, saturated
   function automatic logic [15:0] mix(input logic [15:0] h, input logic [15:0] a, input logic [3:0] m);
      logic [16:0] s;
      s = {h[15], h} + {a[15], a};
      if (m == 4'hF) return h;
      if (s[16] != s[15]) return s[16] ? 16'h8000 : 16'h7FFF;
      return s[15:0];
   endfunction : mix

   task automatic blk(input logic [15:0] iset, input logic [15:0] l, input logic [15:0] r,
                      input logic [15:0] oset);
      int i;
      sendw(iset);
      sendw(l);
      sendw(r);
      sendw(oset);
      rx_valid = 1'b0;
      rx_word = ~rx_word;
      i = 0;
      while (dac_valid !== 1'b1 && i < 4) begin
         step(1);
         i++;
      end
      chk(dac_valid, 1'b1);
      chk(dac_sample, {mix(l, adc_l, iset[7:4]), mix(r, adc_r, iset[7:4])});
      chk(out_cfg, oset & 16'hFF7F);
      chk({in_cfg[15:14], in_cfg[12:0]}, {iset[15:14], iset[12:0]});
      step(1);
      chk(dac_valid, 1'b0);
   endtask : blk

   task automatic adc(input logic [15:0] l, input logic [15:0] r);
      adc_sample = {l, r};
      adc_l = l;
      adc_r = r;
      adc_valid = 1'b1;
      step(1);
      adc_valid = 1'b0;
   endtask : adc

   task automatic over;
      adc_over = 1'b1;
      step(1);
      adc_over = 1'b0;
      step(2);
   endtask : over

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {core_clk, clk_en, reset, stall} = 4'hF;
      {rx_valid, adc_valid, adc_over} = 3'h0;
      {rx_word, adc_l, adc_r} = 48'h0;
      adc_sample = 32'h0000_0000;
      pio_in = 2'h2;
      errors = 0;
      check_count = 0;
      repeat (8) @(posedge core_clk);
      chk(rx_ready, 1'b0);
      chk(out_cfg, 16'h0000);
      chk(in_cfg, 16'h00F0);
      #1 reset = 1'b0;
      step(2);
      chk(rx_ready, 1'b1);
      // second inbound block queues behind a stalled sink
      adc(16'h0064, 16'hFFCE);
      step(3);
      adc(16'h1234, 16'h5678);
      step(10);
      stall = 1'b0;
      wait_words(8);
      step(5);
      exp_w = '{16'h0064, 16'hFFCE, 16'h0000, 16'h80F0, 16'h1234, 16'h5678, 16'h0000, 16'h80F0};
      chk(q.size(), 8);
      foreach (exp_w[k]) begin
         chk(q[k], exp_w[k]);
         chk(u_host.x_space[k], exp_w[k]);
      end
      blk(16'h1AFC, 16'h7000, 16'h0100, 16'hFFFF);
      blk(16'hC50A, 16'h7000, 16'h0100, 16'h4A05);
      // frozen clock enable: offered word must be ignored, slot stays aligned
      clk_en = 1'b0;
      rx_valid = 1'b1;
      rx_word = 16'h1FFF;
      step(2);
      rx_valid = 1'b0;
      clk_en = 1'b1;
      step(1);
      chk(in_cfg, 16'hC50A);
      over();
      chk(in_cfg[13], 1'b0);
      blk(16'h250A, 16'h0010, 16'h0020, 16'h0000);
      chk(in_cfg[13], 1'b0);
      over();
      chk(in_cfg[13], 1'b1);
      blk(16'h250A, 16'h0010, 16'h0020, 16'h0000);
      chk(in_cfg[13], 1'b1);
      blk(16'h050A, 16'h0010, 16'h0020, 16'h0000);
      chk(in_cfg[13], 1'b0);
      blk(16'h050A, 16'h0000, 16'h0000, 16'h0000);
      // mid-run reset restores the settings and realigns the slots
      reset = 1'b1;
      step(1);
      chk(rx_ready, 1'b0);
      chk(out_cfg, 16'h0000);
      chk(in_cfg, 16'h00F0);
      reset = 1'b0;
      step(2);
      chk(rx_ready, 1'b1);
      summarize();
   end

   // watchdog: tests need about 85 cycles, allow over a hundred times that
   initial begin
      #50000;
      errors++;
      summarize();
   end
endmodule : tb
